// file: verilog/asb_select_format.sv
// asb_select_format: converter select buffering, conversion sequencing,
// sleep start and result encoding behind an APB register file.
// assumes the analog front end delivers a signed scaled difference code on
// sample_in (vin*1024/vref, or (vpos-vneg)*1024/vref) from another domain.
//
// Decided for this implementation: the register offsets and register access over APB.
module asb_select_format #(
	parameter int SAMPLE_W = 16 // width of the signed front end code
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire asb_pkg::asb_apb_req_t         apb_req,
	output      asb_pkg::asb_apb_rsp_t         apb_rsp,
	input  wire asb_pkg::asb_sleep_t           sleep_in,
	input  wire logic signed [SAMPLE_W-1:0]    sample_in,
	output      logic [7:0]                    active_select,
	output      logic                          conv_busy,
	output      logic                          conv_irq,
	output      logic                          wake_req
);
	import asb_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// elaboration check: gain of 20 and clamp must fit the intermediate
	if (SAMPLE_W < 11 || SAMPLE_W > 24) begin : g_bad_width
		$error("asb_select_format: SAMPLE_W must lie in 11..24");
	end

	localparam int EXT_W = SAMPLE_W + 6; // room for the 20x product

	// whole state of the block
	typedef struct packed {
		logic [7:0]          select_buf;  // software view of the selection
		logic [7:0]          select_act;  // selection the converter uses
		logic [7:0]          ctrl_a;      // enable/start/auto/flag/ie/prescale
		logic [7:0]          ctrl_b;      // bipolar/left adjust/trigger
		logic [9:0]          result;      // last stored 10-bit code
		logic                res_blocked; // low byte read, high not yet
		logic                lock;        // active selection frozen
		logic                first;       // next conversion is the long one
		logic [6:0]          pre_cnt;     // converter clock divider
		logic [4:0]          tick_cnt;    // converter clocks into conversion
		logic [4:0]          conv_len;    // length of this conversion
		logic [5:0]          conv_sel;    // input select frozen for this conversion
		asb_conv_state_t     state;       // sequencer state
		logic                sleep_done;  // one start per halt
		logic [SAMPLE_W-1:0] samp_meta;   // first synchroniser stage
		logic [SAMPLE_W-1:0] samp_sync;   // second synchroniser stage
		logic [31:0]         rdata;       // read data captured in setup
		logic                rd_err;      // unmapped address seen in setup
	} asb_state_t;

	asb_state_t s_q;
	asb_state_t s_d;

	////////////////////////////////////////////////////////////////////////////
	// result encoder for the three conversion types
	function automatic logic [9:0] asb_encode(
		input logic signed [SAMPLE_W-1:0] smp,
		input logic [5:0]                 sel,
		input logic                       bip
	);
		logic signed [EXT_W-1:0] ext;
		logic signed [EXT_W-1:0] val;
		logic                    single;
		logic [9:0]              code;
		ext    = EXT_W'(smp);
		single = (sel <= ASB_SINGLE_LAST) ||
		         (sel >= ASB_SINGLE_INT_FIRST && sel <= ASB_SINGLE_INT_LAST);
		val    = ext;
		if (!single && sel[0]) begin
			val = (ext <<< 4) + (ext <<< 2);
		end
		if (!single && bip) begin
			val = val >>> 1;
			if (val < ASB_BIP_MIN_VAL) begin
				code = ASB_BIP_MIN_CODE;
			end else if (val > ASB_BIP_MAX_VAL) begin
				code = ASB_BIP_MAX_CODE;
			end else begin
				code = val[9:0];
			end
		end else begin
			if (val < 0) begin
				code = ASB_CODE_MIN;
			end else if (val > ASB_UNI_MAX_VAL) begin
				code = ASB_CODE_MAX;
			end else begin
				code = val[9:0];
			end
		end
		return code;
	endfunction : asb_encode

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic       enable;
		logic       free_run;
		logic       tick;
		logic [6:0] div_m1;
		logic       setup;
		logic       access;
		logic       wr;
		logic       rd;
		logic       done_now;
		logic [15:0] res_word;
		enable   = 1'b0;
		free_run = 1'b0;
		tick     = 1'b0;
		div_m1   = 7'h01;
		setup    = 1'b0;
		access   = 1'b0;
		wr       = 1'b0;
		rd       = 1'b0;
		done_now = 1'b0;
		res_word = 16'h0000;
		s_d      = s_q;

		enable   = s_q.ctrl_a[ASB_CA_ENABLE_POS];
		free_run = s_q.ctrl_a[ASB_CA_AUTO_POS] &&
		           (s_q.ctrl_b[ASB_CB_TRIG_LSB +: 3] == ASB_TRIG_FREE_RUN);

		// pin-side code passes two flops
		s_d.samp_meta = sample_in;
		s_d.samp_sync = s_q.samp_meta;

		// prescaler: divide by 2^ps, ps of zero divides by two
		if (s_q.ctrl_a[ASB_CA_PS_LSB +: 3] != 3'h0) begin
			div_m1 = 7'((8'h01 << s_q.ctrl_a[ASB_CA_PS_LSB +: 3]) - 8'h01);
		end
		// held in reset while the converter is off
		if (!enable) begin
			s_d.pre_cnt = 7'h00;
		end else if (s_q.pre_cnt >= div_m1) begin
			s_d.pre_cnt = 7'h00;
			tick        = 1'b1;
		end else begin
			s_d.pre_cnt = s_q.pre_cnt + 7'h01;
		end

		// apb phases
		setup  = apb_req.psel && !apb_req.penable;
		access = apb_req.psel && apb_req.penable;
		wr     = access && apb_req.pwrite;
		rd     = access && !apb_req.pwrite;

		// result word as software sees it
		// right adjust unless left adjust set
		if (s_q.ctrl_b[ASB_CB_LADJ_POS]) begin
			res_word = {s_q.result, 6'h00};
		end else begin
			res_word = {6'h00, s_q.result};
		end

		// read data captured in setup, shown in access
		if (setup) begin
			s_d.rd_err = 1'b0;
			case (apb_req.paddr)
				ASB_OFF_SELECT:   s_d.rdata = {24'h000000, s_q.select_buf};
				ASB_OFF_CTRL_A:   s_d.rdata = {24'h000000, s_q.ctrl_a};
				ASB_OFF_CTRL_B:   s_d.rdata = {24'h000000, s_q.ctrl_b};
				ASB_OFF_RES_LOW:  s_d.rdata = {24'h000000, res_word[7:0]};
				ASB_OFF_RES_HIGH: s_d.rdata = {24'h000000, res_word[15:8]};
				ASB_OFF_ACTIVE:   s_d.rdata = {24'h000000, s_q.select_act};
				default: begin
					s_d.rdata  = 32'h00000000;
					s_d.rd_err = 1'b1;
				end
			endcase
		end

		// reads of the result bytes steer the update block
		if (rd && apb_req.paddr == ASB_OFF_RES_LOW) begin
			s_d.res_blocked = 1'b1;
		end
		if (rd && apb_req.paddr == ASB_OFF_RES_HIGH) begin
			s_d.res_blocked = 1'b0;
		end

		// register writes
		if (wr) begin
			case (apb_req.paddr)
				ASB_OFF_SELECT: s_d.select_buf = apb_req.pwdata[7:0];
				ASB_OFF_CTRL_A: begin
					s_d.ctrl_a[ASB_CA_ENABLE_POS] = apb_req.pwdata[ASB_CA_ENABLE_POS];
					s_d.ctrl_a[ASB_CA_AUTO_POS]   = apb_req.pwdata[ASB_CA_AUTO_POS];
					s_d.ctrl_a[ASB_CA_IE_POS]     = apb_req.pwdata[ASB_CA_IE_POS];
					s_d.ctrl_a[ASB_CA_PS_LSB +: 3] = apb_req.pwdata[ASB_CA_PS_LSB +: 3];
					// start only sets; hardware clears it
					if (apb_req.pwdata[ASB_CA_START_POS]) begin
						s_d.ctrl_a[ASB_CA_START_POS] = 1'b1;
					end
					// flag clears on a one; a same-cycle set below wins
					if (apb_req.pwdata[ASB_CA_DONE_POS]) begin
						s_d.ctrl_a[ASB_CA_DONE_POS] = 1'b0;
					end
				end
				ASB_OFF_CTRL_B: s_d.ctrl_b = apb_req.pwdata[7:0];
				default: ;
			endcase
		end

		// enable rising arms the long first conversion
		if (!enable && s_d.ctrl_a[ASB_CA_ENABLE_POS]) begin
			s_d.first = 1'b1;
		end

		// halted in a quiet sleep starts a conversion
		// no sleep mode touches the enable bit
		if (!sleep_in.halted) begin
			s_d.sleep_done = 1'b0;
		end else if (!s_q.sleep_done && sleep_in.quiet_mode && enable &&
		             s_q.state == ASB_IDLE && !s_q.ctrl_a[ASB_CA_START_POS] &&
		             !s_q.ctrl_a[ASB_CA_AUTO_POS] && s_q.ctrl_a[ASB_CA_IE_POS]) begin
			s_d.sleep_done               = 1'b1;
			s_d.ctrl_a[ASB_CA_START_POS] = 1'b1;
		end

		// conversion sequencer
		case (s_q.state)
			ASB_IDLE: begin
				if (enable && s_q.ctrl_a[ASB_CA_START_POS]) begin
					s_d.state = ASB_WAIT_EDGE;
				end
			end
			// begin on the next converter clock
			ASB_WAIT_EDGE: begin
				if (tick) begin
					s_d.state    = ASB_CONVERT;
					s_d.tick_cnt = 5'h00;
					s_d.conv_len = s_q.first ? ASB_CONV_FIRST_TICKS : ASB_CONV_NORMAL_TICKS;
					s_d.first    = 1'b0;
					s_d.lock     = 1'b1;
				end
			end
			ASB_CONVERT: begin
				if (tick) begin
					s_d.tick_cnt = s_q.tick_cnt + 5'h01;
					if (s_q.tick_cnt + 5'h01 == s_q.conv_len - 5'h01) begin
						s_d.lock = 1'b0;
					end
					if (s_q.tick_cnt + 5'h01 == s_q.conv_len) begin
						done_now = 1'b1;
					end
				end
			end
			default: s_d.state = ASB_IDLE;
		endcase

		// completion: store, flag, restart or finish
		if (done_now) begin
			// result stored with the flag
			// lost quietly while low byte is held by software
			if (!s_q.res_blocked) begin
				s_d.result = asb_encode($signed(s_q.samp_sync),
				                        s_q.conv_sel,
				                        s_q.ctrl_b[ASB_CB_BIP_POS]);
			end
			// flag raised however the core woke
			s_d.ctrl_a[ASB_CA_DONE_POS] = 1'b1;
			if (free_run) begin
				// restart locks what was copied just now
				s_d.tick_cnt = 5'h00;
				s_d.conv_len = ASB_CONV_NORMAL_TICKS;
				s_d.lock     = 1'b1;
			end else begin
				s_d.state                    = ASB_IDLE;
				s_d.ctrl_a[ASB_CA_START_POS] = 1'b0;
			end
		end

		// switching off aborts any conversion
		if (!s_d.ctrl_a[ASB_CA_ENABLE_POS]) begin
			s_d.state                    = ASB_IDLE;
			s_d.lock                     = 1'b0;
			s_d.ctrl_a[ASB_CA_START_POS] = 1'b0;
		end

		// copied on every cycle of the unlock
		if (!s_q.lock) begin
			s_d.select_act = s_q.select_buf;
		end

		// result coding uses frozen selection
		// the final unlocked cycle may already copy a new selection in
		if (s_d.lock && !s_q.lock) begin
			s_d.conv_sel = s_d.select_act[ASB_SEL_INPUT_LSB +: 6];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.select_buf  <= ASB_SELECT_RST;
			s_q.select_act  <= ASB_SELECT_RST;
			s_q.ctrl_a      <= ASB_CTRL_A_RST;
			s_q.ctrl_b      <= ASB_CTRL_B_RST;
			s_q.result      <= ASB_CODE_MIN;
			s_q.res_blocked <= 1'b0;
			s_q.lock        <= 1'b0;
			s_q.first       <= 1'b1;
			s_q.pre_cnt     <= 7'h00;
			s_q.tick_cnt    <= 5'h00;
			s_q.conv_len    <= ASB_CONV_FIRST_TICKS;
			s_q.conv_sel    <= ASB_SELECT_RST[ASB_SEL_INPUT_LSB +: 6];
			s_q.state       <= ASB_IDLE;
			s_q.sleep_done  <= 1'b0;
			s_q.samp_meta   <= '0;
			s_q.samp_sync   <= '0;
			s_q.rdata       <= 32'h00000000;
			s_q.rd_err      <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs: zero wait state slave, data from flops
	always_comb begin
		apb_rsp.pready  = 1'b1;
		apb_rsp.pslverr = apb_req.psel && apb_req.penable && s_q.rd_err;
		apb_rsp.prdata  = s_q.rdata;
	end

	assign active_select = s_q.select_act;
	assign conv_busy     = s_q.ctrl_a[ASB_CA_START_POS];
	// request stands until software clears the flag
	assign conv_irq      = s_q.ctrl_a[ASB_CA_DONE_POS] && s_q.ctrl_a[ASB_CA_IE_POS];
	// completion request wakes a halted core
	assign wake_req      = conv_irq && sleep_in.halted;

endmodule : asb_select_format

// file: verilog/asb_pkg.sv
// asb_pkg: offsets, field positions, reset values, counts and carrier types
// for the converter select buffer and result formatter.
// assumes a 32-bit APB slave with byte addresses and one word per register.
package asb_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] ASB_OFF_SELECT   = 8'h00; // buffered input/reference select
	localparam logic [7:0] ASB_OFF_CTRL_A   = 8'h04; // enable, start, auto, flag, irq enable, prescale
	localparam logic [7:0] ASB_OFF_CTRL_B   = 8'h08; // bipolar, left adjust, trigger select
	localparam logic [7:0] ASB_OFF_RES_LOW  = 8'h0C; // result low byte
	localparam logic [7:0] ASB_OFF_RES_HIGH = 8'h10; // result high byte
	localparam logic [7:0] ASB_OFF_ACTIVE   = 8'h14; // active (locked) selection, read only

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int ASB_SEL_INPUT_LSB = 0; // input_select_field, 6 bits
	localparam int ASB_SEL_REF_LSB   = 6; // reference_select_field, 2 bits
	localparam int ASB_CA_PS_LSB     = 0; // prescale select, 3 bits
	localparam int ASB_CA_IE_POS     = 3; // completion interrupt enable
	localparam int ASB_CA_DONE_POS   = 4; // conversion_done_flag, write one clears
	localparam int ASB_CA_AUTO_POS   = 5; // auto_trigger_enable
	localparam int ASB_CA_START_POS  = 6; // start_conversion_bit
	localparam int ASB_CA_ENABLE_POS = 7; // converter_enable
	localparam int ASB_CB_TRIG_LSB   = 0; // trigger select, 3 bits
	localparam int ASB_CB_LADJ_POS   = 3; // left_adjust_bit
	localparam int ASB_CB_BIP_POS    = 7; // bipolar_select_bit

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] ASB_SELECT_RST = 8'h00;
	localparam logic [7:0] ASB_CTRL_A_RST = 8'h00;
	localparam logic [7:0] ASB_CTRL_B_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// converter clock counts and codes
	localparam logic [4:0] ASB_CONV_NORMAL_TICKS = 5'h0D; // 13 converter clocks
	localparam logic [4:0] ASB_CONV_FIRST_TICKS  = 5'h19; // 25 converter clocks after enable
	localparam logic [2:0] ASB_TRIG_FREE_RUN     = 3'h0;  // done flag as trigger
	localparam logic [5:0] ASB_SINGLE_LAST       = 6'h07; // last single-ended pin code
	localparam logic [5:0] ASB_SINGLE_INT_FIRST  = 6'h20; // internal single-ended codes
	localparam logic [5:0] ASB_SINGLE_INT_LAST   = 6'h22;
	localparam logic [9:0] ASB_CODE_MIN          = 10'h000;
	localparam logic [9:0] ASB_CODE_MAX          = 10'h3FF;
	localparam logic [9:0] ASB_BIP_MIN_CODE      = 10'h200;
	localparam logic [9:0] ASB_BIP_MAX_CODE      = 10'h1FF;
	localparam int         ASB_UNI_MAX_VAL       = 1023;
	localparam int         ASB_BIP_MIN_VAL       = -512;
	localparam int         ASB_BIP_MAX_VAL       = 511;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} asb_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} asb_apb_rsp_t;

	typedef struct packed {
		logic halted;     // core has stopped executing
		logic quiet_mode; // sleep mode is idle or noise reduction
	} asb_sleep_t;

	typedef enum logic [1:0] {
		ASB_IDLE,
		ASB_WAIT_EDGE,
		ASB_CONVERT
	} asb_conv_state_t;

endpackage : asb_pkg

// file: verif/asb_checker.sv
// asb_checker: port-level properties of the select buffer and formatter.
// assumes one pclk domain, presetn as its only reset, zero wait states.
module asb_checker (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire asb_pkg::asb_apb_req_t apb_req,
	input wire asb_pkg::asb_apb_rsp_t apb_rsp,
	input wire asb_pkg::asb_sleep_t   sleep_in,
	input wire logic [7:0]            active_select,
	input wire logic                  conv_busy,
	input wire logic                  conv_irq,
	input wire logic                  wake_req
);
	timeunit 1ns;
	timeprecision 1ps;
	import asb_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////
	// access phase and control writes
	wire logic acc    = apb_req.psel && apb_req.penable;
	wire logic ctl_wr = acc && apb_req.pwrite && apb_req.paddr == ASB_OFF_CTRL_A;
	// select write while no conversion holds the lock
	sequence s_sel_wr;
		acc && apb_req.pwrite && apb_req.paddr == ASB_OFF_SELECT && !conv_busy;
	endsequence
	// setup then access of an active selection read
	sequence s_act_rd;
		apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == ASB_OFF_ACTIVE ##1 acc;
	endsequence
	////////////////////////////////////////////////////////////////////////////
	a_ready_always: assert property (acc |-> apb_rsp.pready) else $error("wait state seen");
	a_select_follow: assert property (s_sel_wr |=> ##1 active_select == $past(apb_req.pwdata[7:0], 2))
		else $error("active selection did not follow buffer");
	a_active_read: assert property (s_act_rd |-> apb_rsp.prdata == {24'h0, $past(active_select)})
		else $error("active selection read wrong");
	a_unmapped_err: assert property (acc && apb_req.paddr[1:0] == 2'b00
		|-> apb_rsp.pslverr == (apb_req.paddr > ASB_OFF_ACTIVE)) else $error("slave error wrong");
	a_start_busy: assert property (ctl_wr && apb_req.pwdata[7:6] == 2'b11 |=> conv_busy)
		else $error("start not taken");
	a_disable_abort: assert property (ctl_wr && !apb_req.pwdata[7] |=> !conv_busy) else $error("abort failed");
	a_irq_mask: assert property (ctl_wr && !apb_req.pwdata[3] |=> !conv_irq)
		else $error("masked interrupt raised");
	a_wake_gate: assert property (wake_req == (conv_irq && sleep_in.halted))
		else $error("wake request wrong");
endmodule : asb_checker

bind asb_select_format asb_checker asb_checker_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .sleep_in(sleep_in), .active_select(active_select), .conv_busy(conv_busy),
	.conv_irq(conv_irq), .wake_req(wake_req));

// file: verif/asb_front_model.sv
// asb_front_model: stand-in for the analog front end feeding scaled codes.
// assumes the bench sets the level; the ground channel always reads zero.
module asb_front_model (
	input wire logic               pclk,
	input wire logic signed [15:0] level,
	input wire logic [7:0]         active_select,
	output     logic signed [15:0] sample_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import asb_pkg::*;
	// ground input shows zero, so the result proves which channel was active
	always_ff @(posedge pclk) begin
		sample_in <= (active_select[5:0] == ASB_SINGLE_INT_FIRST) ? 16'sh0000 : level;
	end
endmodule : asb_front_model

// file: verif/testbench.sv
// testbench: register-level scenarios for the select buffer and formatter.
// assumes zero wait state apb and prescale 0 (converter tick every 2 pclk).
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import asb_pkg::*;
	logic                pclk;
	logic                presetn;
	asb_apb_req_t        apb_req;
	asb_apb_rsp_t        apb_rsp;
	asb_sleep_t          sleep_in;
	logic signed [15:0]  level;
	logic signed [15:0]  sample_in;
	logic [7:0]          active_select;
	logic                conv_busy;
	logic                conv_irq;
	logic                wake_req;
	logic [31:0]         q;
	logic                e;
	int                  fail_count = 0;
	int                  checks = 0;
	int                  cycles = 0;
	asb_select_format #(.SAMPLE_W(16)) asb_select_format_inst (.pclk(pclk), .presetn(presetn),
		.apb_req(apb_req), .apb_rsp(apb_rsp), .sleep_in(sleep_in), .sample_in(sample_in),
		.active_select(active_select), .conv_busy(conv_busy), .conv_irq(conv_irq), .wake_req(wake_req));
	asb_front_model asb_front_model_inst (.pclk(pclk), .level(level), .active_select(active_select),
		.sample_in(sample_in));
	////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial pclk = 1'b0;
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles >= 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : check
	// one apb transfer, request held until pready seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		// only the hang guard bounds this wait
		do begin
			@(posedge pclk);
		end while (apb_rsp.pready !== 1'b1);
		q = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req.psel    <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
		apb(1'b0, a, 32'h0);
		check(q, exp, m);
	endtask : rd
	// bounded wait for the completion request
	task automatic wait_irq;
		int n;
		n = 0;
		// one edge first: the flag clear of the start write is not yet visible
		do begin
			@(posedge pclk);
			n++;
		end while (conv_irq !== 1'b1 && n < 400);
		check({31'h0, conv_irq}, 32'h1, "completion irq");
	endtask : wait_irq
	// one single conversion, result read low then high
	task automatic conv(input logic [7:0] sel, input logic [7:0] cb, input logic signed [15:0] lvl,
		input logic [9:0] code);
		logic [15:0] x;
		apb(1'b1, ASB_OFF_SELECT, {24'h0, sel});
		level <= lvl;
		apb(1'b1, ASB_OFF_CTRL_B, {24'h0, cb});
		apb(1'b1, ASB_OFF_CTRL_A, 32'hD8);
		wait_irq();
		x = cb[ASB_CB_LADJ_POS] ? {code, 6'h00} : {6'h00, code};
		rd(ASB_OFF_RES_LOW, {24'h0, x[7:0]}, "result low");
		rd(ASB_OFF_RES_HIGH, {24'h0, x[15:8]}, "result high");
	endtask : conv
	////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		rd(ASB_OFF_SELECT, 32'h0, "select reset");
		rd(ASB_OFF_CTRL_A, 32'h0, "ctrl a reset");
		rd(ASB_OFF_CTRL_B, 32'h0, "ctrl b reset");
		apb(1'b0, 8'h18, 32'h0);
		check({31'h0, e}, 32'h1, "unmapped error");
		check(q, 32'h0, "unmapped data");
		$display("test reset done");
	endtask : t_reset
	task automatic t_lock;
		apb(1'b1, ASB_OFF_SELECT, 32'h03);
		level <= 16'sd300;
		apb(1'b1, ASB_OFF_CTRL_A, 32'hD8);
		repeat (6) @(posedge pclk);
		apb(1'b1, ASB_OFF_SELECT, 32'hC5);
		rd(ASB_OFF_ACTIVE, 32'h03, "locked selection");
		rd(ASB_OFF_SELECT, 32'hC5, "buffer readback");
		wait_irq();
		rd(ASB_OFF_ACTIVE, 32'hC5, "selection resumed");
		rd(ASB_OFF_RES_LOW, 32'h2C, "low byte");
		rd(ASB_OFF_RES_HIGH, 32'h01, "high byte");
		apb(1'b1, ASB_OFF_CTRL_A, 32'h90);
		@(negedge pclk);
		check({31'h0, conv_irq}, 32'h0, "flag cleared");
		check({31'h0, conv_busy}, 32'h0, "idle after done");
		$display("test lock done");
	endtask : t_lock
	task automatic t_formats;
		apb(1'b1, ASB_OFF_SELECT, 32'h03);
		apb(1'b1, ASB_OFF_CTRL_A, 32'hD8);
		wait_irq();
		conv(8'h03, 8'h00, 16'sd300, 10'h12C);
		conv(8'h03, 8'h00, 16'sd2000, 10'h3FF);
		conv(8'h20, 8'h00, 16'sd500, 10'h000);
		conv(8'h08, 8'h00, -16'sd50, 10'h000);
		conv(8'h09, 8'h00, 16'sd40, 10'h320);
		conv(8'h08, 8'h00, 16'sd40, 10'h028);
		conv(8'h08, 8'h80, -16'sd1024, 10'h200);
		conv(8'h08, 8'h80, 16'sd100, 10'h032);
		conv(8'h09, 8'h80, 16'sd60, 10'h1FF);
		conv(8'h03, 8'h08, 16'sd301, 10'h12D);
		$display("test formats done");
	endtask : t_formats
	// low byte read blocks the update until the high byte is read
	task automatic t_block;
		conv(8'h03, 8'h00, 16'sd300, 10'h12C);
		rd(ASB_OFF_RES_LOW, 32'h2C, "low held");
		level <= 16'sd600;
		apb(1'b1, ASB_OFF_CTRL_A, 32'hD8);
		wait_irq();
		rd(ASB_OFF_RES_HIGH, 32'h01, "blocked high keeps old");
		rd(ASB_OFF_RES_LOW, 32'h2C, "blocked result lost");
		$display("test block done");
	endtask : t_block
	task automatic t_free;
		apb(1'b1, ASB_OFF_SELECT, 32'h03);
		apb(1'b1, ASB_OFF_CTRL_B, 32'h00);
		apb(1'b1, ASB_OFF_CTRL_A, 32'hF8);
		wait_irq();
		apb(1'b1, ASB_OFF_SELECT, 32'h05);
		rd(ASB_OFF_ACTIVE, 32'h03, "restarted keeps old");
		apb(1'b1, ASB_OFF_CTRL_A, 32'hF8);
		wait_irq();
		rd(ASB_OFF_ACTIVE, 32'h05, "later uses new");
		check({31'h0, conv_busy}, 32'h1, "free run continues");
		apb(1'b1, ASB_OFF_CTRL_A, 32'h00);
		@(negedge pclk);
		check({31'h0, conv_busy}, 32'h0, "disable aborts");
		$display("test free run done");
	endtask : t_free
	task automatic t_sleep;
		apb(1'b1, ASB_OFF_CTRL_A, 32'h98);
		sleep_in <= '{halted: 1'b1, quiet_mode: 1'b0};
		repeat (20) @(posedge pclk);
		sleep_in <= '{halted: 1'b0, quiet_mode: 1'b0};
		rd(ASB_OFF_CTRL_A, 32'h88, "deep sleep keeps enable");
		sleep_in <= '{halted: 1'b1, quiet_mode: 1'b1};
		repeat (4) @(posedge pclk);
		check({31'h0, conv_busy}, 32'h1, "sleep start");
		sleep_in <= '{halted: 1'b0, quiet_mode: 1'b1};
		wait_irq();
		check({31'h0, wake_req}, 32'h0, "awake core no wake");
		sleep_in <= '{halted: 1'b1, quiet_mode: 1'b1};
		@(negedge pclk);
		check({31'h0, wake_req}, 32'h1, "irq wakes core");
		@(posedge pclk);
		sleep_in <= '{halted: 1'b0, quiet_mode: 1'b0};
		$display("test sleep done");
	endtask : t_sleep
	////////////////////////////////////////////////////////////////////////////
	// verdict, reached from the sequence or the hang guard
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		apb_req  = '0;
		sleep_in = '0;
		level    = 16'sh0000;
		presetn  = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_lock();
		t_formats();
		t_block();
		t_free();
		t_sleep();
		give_verdict();
	end
endmodule : testbench
